// ==== shared/hps_defs.vh ====
/*
 * Constants for the heat controller parameter store: service codes,
 * selector encodings, defaults, limits and timing counts.
 * Assumes a 250 MHz system clock; tick and microsecond units are converted to cycles here.
 */
`ifndef HPS_DEFS_VH
`define HPS_DEFS_VH

// ==========================================================
// Service codes
`define HPS_SVC_RESET 8'h05
`define HPS_SVC_RESTORE 8'h15
`define HPS_SVC_SAVE 8'h16
`define HPS_CLASS_INST 8'h00
`define HPS_ID_RESET_TYPE 8'h01

// ==========================================================
// Parameter indices in the store
`define HPS_IDX_SEL 3'h0
`define HPS_IDX_CAL 3'h1
`define HPS_IDX_HTL 3'h2
`define HPS_IDX_MIMP 3'h3
`define HPS_IDX_FMT 3'h4
`define HPS_IDX_RANGE 3'h5
`define HPS_IDX_ALLOY 3'h6
`define HPS_NUM_PARAMS 7

// ==========================================================
// Selector encodings
`define HPS_SEL_300 16'h0000
`define HPS_SEL_500 16'h0004
`define HPS_SEL_PC 16'h0009
`define HPS_SEL_SWITCH 16'h000A
`define HPS_SEL_VAR 16'h000B

// Decoded range / alloy source codes
`define HPS_RNG_300 2'h0
`define HPS_RNG_500 2'h1
`define HPS_SRC_PC 2'h2
`define HPS_SRC_SWITCH 2'h3
`define HPS_ALLOY_1700 2'h0

// ==========================================================
// Defaults and limits
`define HPS_DEF_SEL 16'h000A
`define HPS_DEF_CAL 16'h0014
`define HPS_CAL_MAX 16'h0028
`define HPS_CAL_FROM_INPUT 16'hFFFF
`define HPS_DEF_HTL 16'h01F4
`define HPS_HTL_MAX 16'h03E7
`define HPS_DEF_MIMP_US 16'h06A4
`define HPS_DEF_FMT 16'h0000
`define HPS_DEF_RANGE 16'h0000
`define HPS_DEF_ALLOY 16'h0000

// ==========================================================
// Timing
`define HPS_CLK_MHZ 250
`define HPS_TICK_MS 10
`define HPS_TICK_CYCLES (`HPS_TICK_MS * 1000 * `HPS_CLK_MHZ)
`define HPS_US_CYCLES `HPS_CLK_MHZ

`endif

// ==== hdl/hps_pulse_gen.v ====
/*
 * Measuring impulse generator: a one-shot whose length is given in
 * microseconds. Assumes trig is a single-cycle pulse in sys_clk domain.
 */
`include "hps_defs.vh"

module hps_pulse_gen #(
	parameter US_CYCLES = `HPS_US_CYCLES
) (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// Control
	input wire trig,
	input wire [15:0] len_us,
	// Output
	output reg pulse_r
);

	reg [15:0] us_cnt_r;
	reg [8:0] cyc_cnt_r;

	// ==========================================================
	// One-shot counter
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pulse_r <= 1'b0;
			us_cnt_r <= 16'h0000;
			cyc_cnt_r <= 9'h000;
		end else if (trig && len_us != 16'h0000) begin
			pulse_r <= 1'b1;
			us_cnt_r <= len_us;
			cyc_cnt_r <= 9'h000;
		end else if (pulse_r) begin
			if (cyc_cnt_r == US_CYCLES[8:0] - 9'h001) begin
				cyc_cnt_r <= 9'h000;
				if (us_cnt_r == 16'h0001)
					pulse_r <= 1'b0;
				us_cnt_r <= us_cnt_r - 16'h0001;
			end else begin
				cyc_cnt_r <= cyc_cnt_r + 9'h001;
			end
		end
	end

endmodule // hps_pulse_gen

// ==== hdl/hps_param_store.v ====
/*
 * Parameter store and supervisory settings of an impulse heat-sealing
 * controller: volatile and non-volatile copies, services, selector
 * decode, calibration source, heating time limit, measuring impulse
 * length and byte order.
 * Assumes the network stack presents decoded service and write requests
 * as single-cycle strobes on sys_clk, and that the non-volatile copy is
 * held by an array kept alive across supply loss.
 */
// Operation
// R1: Network writes change only the volatile copy
// R2: Save service copies working set to store
// R3: Restore service reloads working set from store
// R4: Reset service defaults both copies
// R5: Services accepted only at class instance 0
// R6: Identity type 1 reset also defaults parameters
// R7: Power-on loads last saved values
// R8: Decode selector 0,4,9,10,11 to range/alloy
// R9: Selector 11 uses range and alloy instances
// R10: Calibration temperature default 20, range 0..40
// R11: Calibration -1 takes input data field
// R12: Host runs zero calibration after range change
// R13: Heating ends when time limit elapses
// R14: After cutoff, start ignored until released
// R15: Time limit default 5.00 s, 0..999
// R16: Measuring impulse length from parameter, default 1.7ms
// R17: Data format selects cyclic byte order
// R18: Count limit in 10 ms ticks from start
`include "hps_defs.vh"

module hps_param_store #(
	parameter NPARAM = `HPS_NUM_PARAMS,
	parameter TICK_CYCLES = `HPS_TICK_CYCLES,
	parameter US_CYCLES = `HPS_US_CYCLES
) (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// Parameter write and read port
	input wire wr_stb,
	input wire [2:0] wr_idx,
	input wire [15:0] wr_data,
	output wire wr_ack,
	output wire wr_err,
	input wire [2:0] rd_idx,
	output reg [15:0] rd_data_r,
	// Service requests
	input wire svc_stb,
	input wire [7:0] svc_code,
	input wire [7:0] svc_inst,
	output reg svc_done_r,
	output reg svc_err_r,
	input wire id_reset_stb,
	input wire [7:0] id_reset_type,
	// Power-on load request
	input wire power_on_load,
	// Cyclic data and heat control
	input wire start_cmd,
	input wire [15:0] cyc_setpoint,
	input wire [1:0] switch_range,
	input wire [1:0] switch_alloy,
	input wire meas_trig,
	input wire [15:0] cyc_in_raw,
	input wire [15:0] cyc_out_raw,
	// Decoded settings and status
	output reg [1:0] range_sel_r,
	output reg [1:0] alloy_sel_r,
	output reg [15:0] cal_temp_r,
	output reg heat_on_r,
	output reg htl_cutoff_r,
	output reg big_endian_r,
	output reg [15:0] cyc_in_data_r,
	output reg [15:0] cyc_out_data_r,
	output wire meas_pulse,
	output reg zero_cal_request_r
);

	// ==========================================================
	// Storage
	reg [15:0] work_r [0:NPARAM-1];
	reg [15:0] nv_r [0:NPARAM-1];
	reg wr_ok;
	reg svc_ok;
	reg do_save, do_restore, do_default;
	integer i;
	integer j;

	// Defaults as a function: a process reading only constants never runs
	function [15:0] def_of;
		input [2:0] k;
		begin
			case (k)
			`HPS_IDX_SEL: def_of = `HPS_DEF_SEL;
			`HPS_IDX_CAL: def_of = `HPS_DEF_CAL;
			`HPS_IDX_HTL: def_of = `HPS_DEF_HTL;
			`HPS_IDX_MIMP: def_of = `HPS_DEF_MIMP_US;
			`HPS_IDX_FMT: def_of = `HPS_DEF_FMT;
			`HPS_IDX_RANGE: def_of = `HPS_DEF_RANGE;
			default: def_of = `HPS_DEF_ALLOY;
			endcase
		end
	endfunction

	// ==========================================================
	// Write validation
	always @* begin
		wr_ok = 1'b0;
		if (wr_idx < NPARAM) begin
			case (wr_idx)
			`HPS_IDX_CAL: wr_ok = (wr_data <= `HPS_CAL_MAX) ||
				(wr_data == `HPS_CAL_FROM_INPUT); // [R10] [R11]
			`HPS_IDX_HTL: wr_ok = (wr_data <= `HPS_HTL_MAX); // [R15]
			`HPS_IDX_SEL: wr_ok = (wr_data == `HPS_SEL_300) ||
				(wr_data == `HPS_SEL_500) ||
				(wr_data == `HPS_SEL_PC) ||
				(wr_data == `HPS_SEL_SWITCH) ||
				(wr_data == `HPS_SEL_VAR);
			`HPS_IDX_MIMP: wr_ok = (wr_data >= `HPS_DEF_MIMP_US); // [R16]
			default: wr_ok = 1'b1;
			endcase
		end
	end

	assign wr_ack = wr_stb && wr_ok;
	assign wr_err = wr_stb && !wr_ok;

	// ==========================================================
	// Service decode
	always @* begin
		svc_ok = svc_stb && (svc_inst == `HPS_CLASS_INST); // [R5]
		do_save = svc_ok && (svc_code == `HPS_SVC_SAVE);
		do_restore = (svc_ok && (svc_code == `HPS_SVC_RESTORE)) ||
			power_on_load; // [R7]
		do_default = (svc_ok && (svc_code == `HPS_SVC_RESET)) ||
			(id_reset_stb &&
			id_reset_type == `HPS_ID_RESET_TYPE); // [R6]
	end

	// Volatile copy; reset models supply loss, so it reloads defaults
	// here and then power_on_load pulls in the saved set.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			work_r[0] <= `HPS_DEF_SEL; // [R1]
			work_r[1] <= `HPS_DEF_CAL;
			work_r[2] <= `HPS_DEF_HTL;
			work_r[3] <= `HPS_DEF_MIMP_US;
			work_r[4] <= `HPS_DEF_FMT;
			work_r[5] <= `HPS_DEF_RANGE;
			work_r[6] <= `HPS_DEF_ALLOY;
		end else if (do_default) begin
			for (i = 0; i < NPARAM; i = i + 1)
				work_r[i] <= def_of(i[2:0]); // [R4]
		end else if (do_restore) begin
			for (i = 0; i < NPARAM; i = i + 1)
				work_r[i] <= nv_r[i]; // [R3] [R7]
		end else if (wr_ack) begin
			work_r[wr_idx] <= wr_data; // [R1]
		end
	end

	// Non-volatile copy: no reset, survives supply loss by design
	always @(posedge sys_clk) begin
		if (do_default) begin
			for (j = 0; j < NPARAM; j = j + 1)
				nv_r[j] <= def_of(j[2:0]); // [R4]
		end else if (do_save) begin
			for (j = 0; j < NPARAM; j = j + 1)
				nv_r[j] <= work_r[j]; // [R2] [R5]
		end
	end

	// ==========================================================
	// Service answers and read port
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			svc_done_r <= 1'b0;
			svc_err_r <= 1'b0;
			rd_data_r <= 16'h0000;
		end else begin
			svc_done_r <= svc_ok && (svc_code == `HPS_SVC_SAVE ||
				svc_code == `HPS_SVC_RESTORE ||
				svc_code == `HPS_SVC_RESET);
			svc_err_r <= svc_stb && !(svc_ok &&
				(svc_code == `HPS_SVC_SAVE ||
				svc_code == `HPS_SVC_RESTORE ||
				svc_code == `HPS_SVC_RESET)); // [R5]
			rd_data_r <= (rd_idx < NPARAM) ? work_r[rd_idx] : 16'h0000;
		end
	end

	// ==========================================================
	// Pin synchronisers
	// Switch bits count only once two stages agree, so a code held
	// for a single cycle while the switch turns never reaches the decoder.
	reg start_s1_r, start_s2_r, start_s3_r;
	reg [3:0] sw_s1_r;
	reg [3:0] sw_s2_r;
	reg [3:0] sw_s3_r;
	reg [3:0] sw_stable_r;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sw_s1_r <= 4'hF;
			sw_s2_r <= 4'hF;
			sw_s3_r <= 4'hF;
			sw_stable_r <= 4'hF;
		end else begin
			sw_s1_r <= {switch_alloy, switch_range};
			sw_s2_r <= sw_s1_r;
			sw_s3_r <= sw_s2_r;
			if (sw_s2_r == sw_s3_r)
				sw_stable_r <= sw_s3_r;
		end
	end

	// ==========================================================
	// Selector decode
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			range_sel_r <= `HPS_SRC_SWITCH;
			alloy_sel_r <= `HPS_SRC_SWITCH;
		end else begin
			case (work_r[`HPS_IDX_SEL])
			`HPS_SEL_300: begin
				range_sel_r <= `HPS_RNG_300; // [R8]
				alloy_sel_r <= `HPS_ALLOY_1700;
			end
			`HPS_SEL_500: begin
				range_sel_r <= `HPS_RNG_500; // [R8]
				alloy_sel_r <= `HPS_ALLOY_1700;
			end
			`HPS_SEL_PC: begin
				range_sel_r <= `HPS_SRC_PC; // [R8]
				alloy_sel_r <= `HPS_SRC_PC;
			end
			`HPS_SEL_VAR: begin
				range_sel_r <= work_r[`HPS_IDX_RANGE][1:0]; // [R9]
				alloy_sel_r <= work_r[`HPS_IDX_ALLOY][1:0]; // [R9]
			end
			default: begin
				range_sel_r <= sw_stable_r[1:0]; // [R8]
				alloy_sel_r <= sw_stable_r[3:2];
			end
			endcase
		end
	end

	// ==========================================================
	// Calibration source and zero calibration hint
	reg [15:0] sel_prev_r, rng_prev_r, alloy_prev_r;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cal_temp_r <= `HPS_DEF_CAL;
			sel_prev_r <= `HPS_DEF_SEL;
			rng_prev_r <= `HPS_DEF_RANGE;
			alloy_prev_r <= `HPS_DEF_ALLOY;
			zero_cal_request_r <= 1'b0;
		end else begin
			if (work_r[`HPS_IDX_CAL] == `HPS_CAL_FROM_INPUT)
				cal_temp_r <= cyc_setpoint; // [R11]
			else
				cal_temp_r <= work_r[`HPS_IDX_CAL]; // [R10]
			sel_prev_r <= work_r[`HPS_IDX_SEL];
			rng_prev_r <= work_r[`HPS_IDX_RANGE];
			alloy_prev_r <= work_r[`HPS_IDX_ALLOY];
			// Flags the host that zero calibration is due; the host
			// runs it, so the flag only clears while the synchronised start is held.
			if (sel_prev_r != work_r[`HPS_IDX_SEL] ||
				rng_prev_r != work_r[`HPS_IDX_RANGE] ||
				alloy_prev_r != work_r[`HPS_IDX_ALLOY])
				zero_cal_request_r <= 1'b1; // [R12]
			else if (start_s2_r && start_s3_r)
				zero_cal_request_r <= 1'b0;
		end
	end

	// ==========================================================
	// Heating time limit
	reg [31:0] tick_cnt_r;
	reg [15:0] htl_cnt_r;

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			start_s1_r <= 1'b0;
			start_s2_r <= 1'b0;
			start_s3_r <= 1'b0;
		end else begin
			start_s1_r <= start_cmd;
			start_s2_r <= start_s1_r;
			start_s3_r <= start_s2_r;
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			heat_on_r <= 1'b0;
			htl_cutoff_r <= 1'b0;
			tick_cnt_r <= 32'h00000000;
			htl_cnt_r <= 16'h0000;
		end else if (start_s2_r && start_s3_r) begin
			if (!heat_on_r && !htl_cutoff_r) begin
				heat_on_r <= 1'b1; // [R18]
				tick_cnt_r <= 32'h00000000;
				htl_cnt_r <= 16'h0000;
			end else if (heat_on_r) begin
				if (htl_cnt_r >= work_r[`HPS_IDX_HTL]) begin
					heat_on_r <= 1'b0; // [R13]
					htl_cutoff_r <= 1'b1; // [R14]
				end else if (tick_cnt_r == TICK_CYCLES - 1) begin
					tick_cnt_r <= 32'h00000000;
					htl_cnt_r <= htl_cnt_r + 16'h0001; // [R18]
				end else begin
					tick_cnt_r <= tick_cnt_r + 32'h00000001;
				end
			end
		end else if (!start_s2_r && !start_s3_r) begin
			heat_on_r <= 1'b0;
			htl_cutoff_r <= 1'b0; // [R14]
		end
	end

	// ==========================================================
	// Byte order of cyclic data
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			big_endian_r <= 1'b0;
			cyc_in_data_r <= 16'h0000;
			cyc_out_data_r <= 16'h0000;
		end else begin
			big_endian_r <= work_r[`HPS_IDX_FMT][0]; // [R17]
			cyc_in_data_r <= work_r[`HPS_IDX_FMT][0] ?
				{cyc_in_raw[7:0], cyc_in_raw[15:8]} : cyc_in_raw;
			cyc_out_data_r <= work_r[`HPS_IDX_FMT][0] ?
				{cyc_out_raw[7:0], cyc_out_raw[15:8]} : cyc_out_raw;
		end
	end

	// ==========================================================
	// Measuring impulse
	hps_pulse_gen #(
		.US_CYCLES(US_CYCLES)
	) u_meas (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.trig(meas_trig),
		.len_us(work_r[`HPS_IDX_MIMP]), // [R16]
		.pulse_r(meas_pulse)
	);

endmodule // hps_param_store

// ==== test/hps_param_store_checker.sv ====
/* Port checker for hps_param_store.
   Assumes it is bound to the top module; one clock, async low reset. */
module hps_param_store_checker #(
	parameter NPARAM = 7,
	parameter TICK_CYCLES = 10
) (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	// Requests
	input wire wr_stb,
	input wire [2:0] wr_idx,
	input wire [15:0] wr_data,
	input wire svc_stb,
	input wire [7:0] svc_code,
	input wire [7:0] svc_inst,
	input wire start_cmd,
	input wire [15:0] cyc_in_raw,
	// Answers
	input wire wr_ack,
	input wire wr_err,
	input wire svc_done_r,
	input wire svc_err_r,
	input wire heat_on_r,
	input wire htl_cutoff_r,
	input wire big_endian_r,
	input wire [15:0] cyc_in_data_r,
	input wire [1:0] range_sel_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// Helpers
	// Longest legal heat: 999 ticks plus one tick and sync slack
	localparam int HMAX = 1000 * TICK_CYCLES + 8;
	int heat_cnt_r;
	wire [15:0] raw_swap = {cyc_in_raw[7:0], cyc_in_raw[15:8]};
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			heat_cnt_r <= 0;
		else
			heat_cnt_r <= heat_on_r ? heat_cnt_r + 1 : 0;
	end
	// ==========================================================
	// Properties
	a_svc_accept: assert property (svc_stb && svc_inst == 8'h00 &&
		(svc_code == 8'h05 || svc_code == 8'h15 || svc_code == 8'h16)
		|=> svc_done_r && !svc_err_r) else $error("service not done");
	a_svc_refuse: assert property (svc_stb && svc_inst != 8'h00
		|=> svc_err_r && !svc_done_r) else $error("service not refused");
	a_cal_refuse: assert property (wr_stb && wr_idx == 3'h1 &&
		wr_data > 16'h0028 && wr_data != 16'hFFFF |-> wr_err && !wr_ack)
		else $error("bad calibration accepted");
	a_cal_accept: assert property (wr_stb && wr_idx == 3'h1 &&
		wr_data <= 16'h0028 |-> wr_ack && !wr_err)
		else $error("good calibration refused");
	a_htl_refuse: assert property (wr_stb && wr_idx == 3'h2 &&
		wr_data > 16'h03E7 |-> wr_err) else $error("bad limit accepted");
	a_sel_decode: assert property (wr_stb && wr_idx == 3'h0 &&
		wr_data == 16'h0004 |-> ##[1:4] range_sel_r == 2'h1)
		else $error("selector 4 not decoded");
	a_cutoff_off: assert property (htl_cutoff_r |-> !heat_on_r)
		else $error("heating during cutoff");
	a_cutoff_hold: assert property ((start_cmd [*5] ##0 htl_cutoff_r)
		|=> htl_cutoff_r) else $error("cutoff left while start held");
	a_heat_limit: assert property (heat_cnt_r <= HMAX)
		else $error("heating past the limit");
	a_swap_order: assert property (big_endian_r && $past(big_endian_r)
		|-> cyc_in_data_r == $past(raw_swap)) else $error("byte order");
endmodule // hps_param_store_checker

// ==== test/hps_scanner_model.sv ====
/* Host-side model driving the start command.
   Assumes go is set by non-blocking assignment at the falling edge. */
module hps_scanner_model (
	// Clock
	input wire sys_clk,
	// Bench control
	input wire go,
	input wire [15:0] hold,
	// Start command to the device
	output logic start_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	int left_r;
	initial start_cmd = 1'b0;
	always @(negedge sys_clk) begin
		if (go && !start_cmd) begin
			start_cmd <= 1'b1;
			left_r <= hold;
		end else if (start_cmd) begin
			// Releases after the hold, so a cutoff can be left again
			if (left_r == 0)
				start_cmd <= 1'b0;
			left_r <= left_r - 1;
		end
	end
endmodule // hps_scanner_model

// ==== test/test_heat_controller_parameter_store.sv ====
/* Self-checking bench for hps_param_store.
   Assumes TICK_CYCLES of 10 and the host model for the start command. */
`include "hps_defs.vh"
module test_heat_controller_parameter_store;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, resetn, wr_stb, svc_stb, id_reset_stb, power_on_load;
	logic meas_trig, go;
	logic [2:0] wr_idx, rd_idx;
	logic [15:0] wr_data, cyc_setpoint, cyc_in_raw, cyc_out_raw, hold, v;
	logic [7:0] svc_code, svc_inst, id_reset_type;
	logic [1:0] switch_range, switch_alloy;
	wire wr_ack, wr_err, svc_done_r, svc_err_r, heat_on_r, htl_cutoff_r;
	wire big_endian_r, meas_pulse, zero_cal_request_r, start_cmd;
	wire [15:0] rd_data_r, cal_temp_r, cyc_in_data_r, cyc_out_data_r;
	wire [1:0] range_sel_r, alloy_sel_r;
	int err_total, cmp_count, n;
	logic [15:0] sv[5] = '{16'h0000, 16'h0004, 16'h0009, 16'h000A, 16'h000B};
	logic [15:0] defs[7] = '{`HPS_DEF_SEL, `HPS_DEF_CAL, `HPS_DEF_HTL,
		`HPS_DEF_MIMP_US, `HPS_DEF_FMT, `HPS_DEF_RANGE, `HPS_DEF_ALLOY};
	hps_param_store #(.TICK_CYCLES(10), .US_CYCLES(2)) dut (
		.sys_clk(sys_clk), .resetn(resetn), .wr_stb(wr_stb), .wr_idx(wr_idx),
		.wr_data(wr_data), .wr_ack(wr_ack), .wr_err(wr_err), .rd_idx(rd_idx),
		.rd_data_r(rd_data_r), .svc_stb(svc_stb), .svc_code(svc_code),
		.svc_inst(svc_inst), .svc_done_r(svc_done_r), .svc_err_r(svc_err_r),
		.id_reset_stb(id_reset_stb), .id_reset_type(id_reset_type),
		.power_on_load(power_on_load), .start_cmd(start_cmd),
		.cyc_setpoint(cyc_setpoint), .switch_range(switch_range),
		.switch_alloy(switch_alloy), .meas_trig(meas_trig),
		.cyc_in_raw(cyc_in_raw), .cyc_out_raw(cyc_out_raw),
		.range_sel_r(range_sel_r), .alloy_sel_r(alloy_sel_r),
		.cal_temp_r(cal_temp_r), .heat_on_r(heat_on_r),
		.htl_cutoff_r(htl_cutoff_r), .big_endian_r(big_endian_r),
		.cyc_in_data_r(cyc_in_data_r), .cyc_out_data_r(cyc_out_data_r),
		.meas_pulse(meas_pulse), .zero_cal_request_r(zero_cal_request_r));
	hps_scanner_model u_host (.sys_clk(sys_clk), .go(go), .hold(hold),
		.start_cmd(start_cmd));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// ==========================================================
	// Expectations and bus tasks
	function logic [3:0] exp_sel(input logic [15:0] s);
		case (s)
			16'h0000: return 4'h0;
			16'h0004: return 4'h1;
			16'h0009: return 4'hA;
			16'h000B: return 4'h1;
			default: return {switch_alloy, switch_range};
		endcase
	endfunction
	function logic [15:0] order(input logic [15:0] w, input int f);
		return f ? {w[7:0], w[15:8]} : w;
	endfunction
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wr(input logic [2:0] i, input logic [15:0] d, input logic e);
		@(negedge sys_clk);
		wr_stb = 1'b1;
		wr_idx = i;
		wr_data = d;
		#1 chk(wr_err, e);
		chk(wr_ack, !e);
		@(negedge sys_clk);
		wr_stb = 1'b0;
	endtask
	task rd(input logic [2:0] i, input logic [15:0] e);
		@(negedge sys_clk);
		rd_idx = i;
		@(negedge sys_clk);
		chk(rd_data_r, e);
	endtask
	task svc(input logic [7:0] c, input logic [7:0] i, input logic [1:0] e);
		@(negedge sys_clk);
		svc_stb = 1'b1;
		svc_code = c;
		svc_inst = i;
		@(negedge sys_clk);
		svc_stb = 1'b0;
		chk({svc_done_r, svc_err_r}, e);
	endtask
	task pulse(input int sel, input logic [7:0] t);
		@(negedge sys_clk);
		power_on_load = (sel == 0);
		id_reset_stb = (sel == 1);
		id_reset_type = t;
		@(negedge sys_clk);
		power_on_load = 1'b0;
		id_reset_stb = 1'b0;
	endtask
	task heat(input logic [15:0] h, input int lo);
		@(negedge sys_clk);
		go <= 1'b1;
		hold <= h;
		@(negedge sys_clk);
		go <= 1'b0;
		n = 0;
		while (!heat_on_r && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		n = 0;
		while (heat_on_r && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n >= lo - 1 && n <= lo + 3, 1'b1);
		chk(htl_cutoff_r, 1'b1);
		wait (!start_cmd);
		repeat (8) @(negedge sys_clk);
		chk(htl_cutoff_r, 1'b0);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(58));
		{err_total, cmp_count, resetn, wr_stb, svc_stb, go} = '0;
		{id_reset_stb, power_on_load, meas_trig, hold} = '0;
		{wr_idx, rd_idx, wr_data, svc_code, svc_inst, id_reset_type} = '0;
		cyc_setpoint = 16'h0000;
		cyc_in_raw = $urandom;
		cyc_out_raw = $urandom;
		switch_range = $urandom;
		switch_alloy = $urandom;
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		for (int k = 0; k < 7; k++)
			rd(3'(k), defs[k]);
		chk({alloy_sel_r, range_sel_r}, exp_sel(`HPS_DEF_SEL));
		chk(cal_temp_r, `HPS_DEF_CAL);
		heat(16'd6000, 5000);
		wr(3'h2, 16'h03E7, 1'b0);
		wr(3'h2, 16'h03E8, 1'b1);
		wr(3'h2, 16'h0003, 1'b0);
		heat(16'd100, 30);
		wr(3'h5, 16'h0001, 1'b0);
		wr(3'h6, 16'h0000, 1'b0);
		for (int k = 0; k < 5; k++) begin
			wr(3'h0, sv[k], 1'b0);
			repeat (5) @(negedge sys_clk);
			chk({alloy_sel_r, range_sel_r}, exp_sel(sv[k]));
		end
		wr(3'h0, 16'h0005, 1'b1);
		chk(zero_cal_request_r, 1'b1);
		repeat (6) begin
			v = $urandom_range(40, 0);
			wr(3'h1, v, 1'b0);
			rd(3'h1, v);
		end
		wr(3'h1, 16'($urandom_range(65534, 41)), 1'b1);
		wr(3'h1, 16'hFFFF, 1'b0);
		cyc_setpoint = $urandom_range(40, 0);
		repeat (4) @(negedge sys_clk);
		chk(cal_temp_r, cyc_setpoint);
		wr(3'h3, 16'd1699, 1'b1);
		wr(3'h3, 16'd1800, 1'b0);
		@(negedge sys_clk);
		meas_trig = 1'b1;
		@(negedge sys_clk);
		meas_trig = 1'b0;
		n = 0;
		while (meas_pulse && n < 5000) begin
			@(negedge sys_clk);
			n++;
		end
		// Bench runs two cycles per microsecond
		chk(16'(n), 16'(1800 * 2));
		for (int f = 0; f < 2; f++) begin
			wr(3'h4, 16'(f), 1'b0);
			@(negedge sys_clk);
			chk(big_endian_r, f[0]);
			repeat (3) begin
				cyc_in_raw = $urandom;
				cyc_out_raw = $urandom;
				repeat (2) @(negedge sys_clk);
				chk(cyc_in_data_r, order(cyc_in_raw, f));
				chk(cyc_out_data_r, order(cyc_out_raw, f));
			end
		end
		wr(3'h1, 16'h0007, 1'b0);
		svc(8'h16, 8'h00, 2'b10);
		wr(3'h1, 16'h001E, 1'b0);
		svc(8'h15, 8'h00, 2'b10);
		rd(3'h1, 16'h0007);
		svc(8'h16, 8'h01, 2'b01);
		svc(8'h33, 8'h00, 2'b01);
		// Supply loss: only the saved copy survives
		@(negedge sys_clk);
		resetn = 1'b0;
		repeat (3) @(negedge sys_clk);
		resetn = 1'b1;
		rd(3'h1, `HPS_DEF_CAL);
		pulse(0, 8'h00);
		rd(3'h1, 16'h0007);
		svc(8'h05, 8'h00, 2'b10);
		rd(3'h1, `HPS_DEF_CAL);
		pulse(0, 8'h00);
		rd(3'h1, `HPS_DEF_CAL);
		wr(3'h1, 16'h0009, 1'b0);
		pulse(1, 8'h02);
		rd(3'h1, 16'h0009);
		pulse(1, 8'h01);
		rd(3'h1, `HPS_DEF_CAL);
		print_verdict;
	end
	// Whole run is near 10k cycles; allow several times that
	initial begin
		#200000;
		err_total++;
		print_verdict;
	end
endmodule // test_heat_controller_parameter_store
bind hps_param_store hps_param_store_checker #(.NPARAM(NPARAM),
	.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.sys_clk(sys_clk), .resetn(resetn), .wr_stb(wr_stb), .wr_idx(wr_idx),
	.wr_data(wr_data), .svc_stb(svc_stb), .svc_code(svc_code),
	.svc_inst(svc_inst), .start_cmd(start_cmd), .cyc_in_raw(cyc_in_raw),
	.wr_ack(wr_ack), .wr_err(wr_err), .svc_done_r(svc_done_r),
	.svc_err_r(svc_err_r), .heat_on_r(heat_on_r),
	.htl_cutoff_r(htl_cutoff_r), .big_endian_r(big_endian_r),
	.cyc_in_data_r(cyc_in_data_r), .range_sel_r(range_sel_r));
